// [pwm_gen_b_defs.svh]
// register indexes, field positions, reset values and widths of the generator B control block
// assumes: included by bare name from the package and the design modules
`ifndef PWM_GEN_B_DEFS_SVH
`define PWM_GEN_B_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_ENABLE_CTRL 7'h28
`define IDX_RELOAD_FREQ 7'h29
`define IDX_COUNTER 7'h2A
`define IDX_MODULUS 7'h2C
`define IDX_PULSE_TWO 7'h40
`define IDX_PULSE_THREE 7'h41
`define IDX_EVENT_STATUS 7'h50
`define IDX_EVENT_MASK 7'h51

// enable control fields
`define BIT_RUN_ENABLE 7
`define BIT_LOAD_OKAY 1
`define BIT_RELOAD_IRQ_EN 0

// reload frequency control fields
`define LSB_INTERVAL 4
`define BIT_HALF_RELOAD 3
`define LSB_DIVIDER 1
`define BIT_RELOAD_FLAG 0

// event status bits
`define EV_RELOAD 0
`define EV_LOADED 1

// widths
`define MOD_W 15
`define PW_W 16

// reset values
`define RST_MODULUS 15'h0001
`define RST_PULSE 16'h0000
`define RST_INTERVAL 4'h0
`define RST_DIVIDER 2'h0

`endif

// [pwm_gen_b_pkg.sv]
// state types of the generator B control block and its period counter
// assumes: pwm_gen_b_defs.svh on the include path
`include "pwm_gen_b_defs.svh"

package pwm_gen_b_pkg;

    typedef enum logic [0:0] {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_type;

    typedef struct packed {
        logic [2:0] div;
        logic [`MOD_W-1:0] cnt;
        count_dir_type dir;
        logic start;
        logic half;
    } counter_state_type;

    typedef struct packed {
        logic run;
        logic ldok;
        logic rie;
        logic ldok_arm;
        logic flag_arm;
        logic flag;
        logic half;
        logic [3:0] ivl_buf;
        logic [3:0] ivl_act;
        logic [3:0] opp_cnt;
        logic [1:0] presc_buf;
        logic [1:0] presc_act;
        logic [`MOD_W-1:0] mod_buf;
        logic [`MOD_W-1:0] mod_act;
        logic [`PW_W-1:0] pw2_buf;
        logic [`PW_W-1:0] pw2_act;
        logic [`PW_W-1:0] pw3_buf;
        logic [`PW_W-1:0] pw3_act;
        logic [31:0] rdata;
        logic pin2;
        logic pin3;
        logic [1:0] ev_sts;
        logic [1:0] ev_mask;
    } ctrl_state_type;

endpackage

// [pwm_gen_b_counter.sv]
// prescaled period counter of generator B, edge or center aligned
// assumes: modulus never zero; run low holds the counter at zero
`timescale 1ns/1ps
`default_nettype none
`include "pwm_gen_b_defs.svh"

module pwm_gen_b_counter (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // control
    input wire logic run_in,
    input wire logic center_in,
    input wire logic [1:0] divider_in,
    input wire logic [`MOD_W-1:0] modulus_in,
    // state
    output logic [`MOD_W-1:0] count_out,
    output logic cycle_start_out,
    output logic half_out
);

    pwm_gen_b_pkg::counter_state_type s_q;
    pwm_gen_b_pkg::counter_state_type s_d;
    logic [2:0] div_last;
    logic tick;

    always_comb begin
        case (divider_in)
            2'h0: div_last = 3'h0;
            2'h1: div_last = 3'h1;
            2'h2: div_last = 3'h3;
            default: div_last = 3'h7;
        endcase
    end

    assign tick = (s_q.div >= div_last);

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.half = 1'b0;
        if (!run_in) begin
            s_d.div = 3'h0;
            s_d.cnt = '0;
            s_d.dir = pwm_gen_b_pkg::DIR_UP;
        end else if (!tick) begin
            s_d.div = 3'(s_q.div + 3'h1);
        end else begin
            s_d.div = 3'h0;
            if (center_in && s_q.dir == pwm_gen_b_pkg::DIR_DOWN) begin
                if (s_q.cnt <= `MOD_W'(1)) begin
                    s_d.cnt = '0;
                    s_d.dir = pwm_gen_b_pkg::DIR_UP;
                    s_d.start = 1'b1;
                end else begin
                    s_d.cnt = `MOD_W'(s_q.cnt - `MOD_W'(1));
                end
            end else if (center_in) begin
                // entering the top is the half-cycle point: both halves last modulus ticks
                if (s_q.cnt >= `MOD_W'(modulus_in - `MOD_W'(1))) begin
                    s_d.cnt = modulus_in;
                    s_d.dir = pwm_gen_b_pkg::DIR_DOWN;
                    s_d.half = 1'b1;
                end else begin
                    s_d.cnt = `MOD_W'(s_q.cnt + `MOD_W'(1));
                end
            end else begin
                s_d.dir = pwm_gen_b_pkg::DIR_UP;
                if (s_q.cnt >= `MOD_W'(modulus_in - `MOD_W'(1))) begin
                    s_d.cnt = '0;
                    s_d.start = 1'b1;
                end else begin
                    s_d.cnt = `MOD_W'(s_q.cnt + `MOD_W'(1));
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign count_out = s_q.cnt;
    assign cycle_start_out = s_q.start;
    assign half_out = s_q.half;

endmodule
`default_nettype wire

// [pwm_gen_b_reload_control.sv]
// generator B enable, buffered load and reload timing with an APB register slave
// assumes: mode and override inputs come from logic on core_clk_in; one APB master
//
// Function
// - control registers except event status and mask take writes only in multi-generator mode; else key bits read zero
// - run enable bit 7 runs generator and pins two, three; else inactive unless overridden
// - load-okay bit 1 moves buffered divider, modulus, pulse widths in at next reload
// - load-okay set by read-zero-then-write-one; cleared by load, written zero, reset
// - bit 0 lets the reload flag request an interrupt
// - interval field bits 7-4 gives a reload every value-plus-one opportunities
// - new interval acts when the current load cycle ends; reads return buffered value
// - bit 3 adds half-cycle reload opportunities, center-aligned only
// - divider field bits 2-1 divides the counting clock by 1, 2, 4 or 8
// - divider becomes active at next reload only with load-okay set
// - reload flag bit 0 set at every reload regardless of load-okay
// - flag cleared by read-while-set then write one; a reload in between voids it
// - clearing the reload flag withdraws the pending reload interrupt
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_gen_b_defs.svh"

module pwm_gen_b_reload_control #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // unit context
    input wire logic multi_generator_mode_in,
    input wire logic center_aligned_in,
    input wire logic [1:0] output_override_control_in,
    input wire logic [1:0] override_level_in,
    // pins and interrupts
    output logic output_pin_two_out,
    output logic output_pin_three_out,
    output logic gen_b_reload_irq_out,
    output logic irq_out
);

    pwm_gen_b_pkg::ctrl_state_type s_q;
    pwm_gen_b_pkg::ctrl_state_type s_d;
    logic [6:0] idx;
    logic hit;
    logic acc;
    logic acc_wr;
    logic acc_rd;
    logic multi_generator_mode;
    logic run_eff;
    logic wr_en;
    logic wr_fq;
    logic [`MOD_W-1:0] count;
    logic cyc_start;
    logic half_pt;
    logic opp;
    logic reload;
    logic pwm_high;

    assign idx = paddr_in[8:2];
    assign acc = psel_in && penable_in;
    assign acc_wr = acc && pwrite_in;
    assign acc_rd = acc && !pwrite_in;
    assign multi_generator_mode = multi_generator_mode_in;
    assign run_eff = s_q.run && multi_generator_mode;
    assign wr_en = acc_wr && multi_generator_mode && idx == `IDX_ENABLE_CTRL;
    assign wr_fq = acc_wr && multi_generator_mode && idx == `IDX_RELOAD_FREQ;

    always_comb begin
        case (idx)
            `IDX_ENABLE_CTRL, `IDX_RELOAD_FREQ, `IDX_COUNTER, `IDX_MODULUS,
            `IDX_PULSE_TWO, `IDX_PULSE_THREE, `IDX_EVENT_STATUS, `IDX_EVENT_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // next values: the first tick after a reload already runs on the new divider and modulus
    pwm_gen_b_counter counter_u (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .run_in(run_eff),
        .center_in(center_aligned_in),
        .divider_in(s_d.presc_act),
        .modulus_in(s_d.mod_act),
        .count_out(count),
        .cycle_start_out(cyc_start),
        .half_out(half_pt)
    );

    // half points come only from a center-aligned counter
    assign opp = run_eff && (cyc_start || (half_pt && s_q.half));
    assign reload = opp && (s_q.opp_cnt >= s_q.ivl_act);
    assign pwm_high = {1'b0, count} < s_q.pw2_act;

    always_comb begin
        s_d = s_q;
        // read data captured in the setup cycle so it leaves a flip-flop
        if (psel_in && !penable_in) begin
            s_d.rdata = 32'h0000_0000;
            case (idx)
                `IDX_ENABLE_CTRL: begin
                    s_d.rdata[`BIT_RUN_ENABLE] = s_q.run && multi_generator_mode;
                    s_d.rdata[`BIT_LOAD_OKAY] = s_q.ldok && multi_generator_mode;
                    s_d.rdata[`BIT_RELOAD_IRQ_EN] = s_q.rie && multi_generator_mode;
                end
                `IDX_RELOAD_FREQ: begin
                    s_d.rdata[7:4] = s_q.ivl_buf;
                    s_d.rdata[`BIT_HALF_RELOAD] = s_q.half;
                    s_d.rdata[2:1] = s_q.presc_buf;
                    s_d.rdata[`BIT_RELOAD_FLAG] = s_q.flag;
                end
                `IDX_COUNTER: s_d.rdata[`MOD_W-1:0] = count;
                `IDX_MODULUS: s_d.rdata[`MOD_W-1:0] = s_q.mod_buf;
                `IDX_PULSE_TWO: s_d.rdata[`PW_W-1:0] = s_q.pw2_buf;
                `IDX_PULSE_THREE: s_d.rdata[`PW_W-1:0] = s_q.pw3_buf;
                `IDX_EVENT_STATUS: s_d.rdata[1:0] = s_q.ev_sts;
                `IDX_EVENT_MASK: s_d.rdata[1:0] = s_q.ev_mask;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // read halves of the two handshakes
        if (acc_rd && idx == `IDX_ENABLE_CTRL && !s_q.rdata[`BIT_LOAD_OKAY]) begin
            s_d.ldok_arm = 1'b1;
        end
        if (acc_rd && idx == `IDX_RELOAD_FREQ && s_q.rdata[`BIT_RELOAD_FLAG]) begin
            s_d.flag_arm = 1'b1;
        end
        if (wr_en) begin
            s_d.run = pwdata_in[`BIT_RUN_ENABLE];
            s_d.rie = pwdata_in[`BIT_RELOAD_IRQ_EN];
            if (!pwdata_in[`BIT_LOAD_OKAY]) begin
                s_d.ldok = 1'b0;
            end else if (s_q.ldok_arm) begin
                s_d.ldok = 1'b1;
            end
            s_d.ldok_arm = 1'b0;
        end
        if (wr_fq) begin
            s_d.ivl_buf = pwdata_in[7:4];
            s_d.half = pwdata_in[`BIT_HALF_RELOAD];
            s_d.presc_buf = pwdata_in[2:1];
            if (pwdata_in[`BIT_RELOAD_FLAG] && s_q.flag_arm) begin
                s_d.flag = 1'b0;
            end
            s_d.flag_arm = 1'b0;
        end
        if (acc_wr && multi_generator_mode && idx == `IDX_MODULUS) begin
            s_d.mod_buf = pwdata_in[`MOD_W-1:0];
        end
        if (acc_wr && multi_generator_mode && idx == `IDX_PULSE_TWO) begin
            s_d.pw2_buf = pwdata_in[`PW_W-1:0];
        end
        if (acc_wr && multi_generator_mode && idx == `IDX_PULSE_THREE) begin
            s_d.pw3_buf = pwdata_in[`PW_W-1:0];
        end
        if (acc_wr && idx == `IDX_EVENT_STATUS) begin
            s_d.ev_sts = s_q.ev_sts & ~pwdata_in[1:0];
        end
        if (acc_wr && idx == `IDX_EVENT_MASK) begin
            s_d.ev_mask = pwdata_in[1:0];
        end
        // opportunity counting; reload handled last so its sets win over clears
        if (opp && !reload) begin
            s_d.opp_cnt = 4'(s_q.opp_cnt + 4'h1);
        end
        if (reload) begin
            s_d.opp_cnt = 4'h0;
            s_d.ivl_act = s_q.ivl_buf;
            s_d.flag = 1'b1;
            s_d.flag_arm = 1'b0;
            s_d.ev_sts[`EV_RELOAD] = 1'b1;
            if (s_q.ldok) begin
                s_d.presc_act = s_q.presc_buf;
                s_d.mod_act = s_q.mod_buf;
                s_d.pw2_act = s_q.pw2_buf;
                s_d.pw3_act = s_q.pw3_buf;
                s_d.ldok = 1'b0;
                s_d.ev_sts[`EV_LOADED] = 1'b1;
            end
        end
        // complementary pair, deadtime applied downstream
        s_d.pin2 = output_override_control_in[0] ? override_level_in[0] : (run_eff && pwm_high);
        s_d.pin3 = output_override_control_in[1] ? override_level_in[1] : (run_eff && !pwm_high);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.ivl_buf <= `RST_INTERVAL;
            s_q.ivl_act <= `RST_INTERVAL;
            s_q.presc_buf <= `RST_DIVIDER;
            s_q.presc_act <= `RST_DIVIDER;
            s_q.mod_buf <= `RST_MODULUS;
            s_q.mod_act <= `RST_MODULUS;
            s_q.pw2_buf <= `RST_PULSE;
            s_q.pw2_act <= `RST_PULSE;
            s_q.pw3_buf <= `RST_PULSE;
            s_q.pw3_act <= `RST_PULSE;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign prdata_out = s_q.rdata;
    assign pready_out = acc;
    assign pslverr_out = acc && !hit;
    assign output_pin_two_out = s_q.pin2;
    assign output_pin_three_out = s_q.pin3;
    assign gen_b_reload_irq_out = s_q.flag && s_q.rie && multi_generator_mode;
    assign irq_out = |(s_q.ev_sts & s_q.ev_mask);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_mode_gate;
        (acc_wr && !multi_generator_mode && idx == `IDX_ENABLE_CTRL && ce_in && !reload) |=> $stable(s_q.ldok);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("enable written outside mode");

    property p_pins_idle;
        (!run_eff && output_override_control_in == 2'h0 && ce_in)
            |=> (!output_pin_two_out && !output_pin_three_out);
    endproperty
    a_pins_idle: assert property (p_pins_idle) else $error("pins active while stopped");

    property p_load_copy;
        (reload && s_q.ldok && ce_in) |=> (s_q.mod_act == $past(s_q.mod_buf)
            && s_q.pw2_act == $past(s_q.pw2_buf) && !s_q.ldok);
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("buffers not loaded");

    property p_ldok_needs_read;
        (wr_en && pwdata_in[`BIT_LOAD_OKAY] && !s_q.ldok_arm && !s_q.ldok && ce_in) |=> !s_q.ldok;
    endproperty
    a_ldok_needs_read: assert property (p_ldok_needs_read) else $error("load-okay set unarmed");

    property p_irq_follow;
        (reload && ce_in) |=> (gen_b_reload_irq_out == (s_q.rie && multi_generator_mode));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("reload irq missing");

    property p_interval;
        (reload && ce_in) |=> (s_q.opp_cnt == 4'h0 && s_q.ivl_act == $past(s_q.ivl_buf));
    endproperty
    a_interval: assert property (p_interval) else $error("interval not applied at reload");

    property p_divider_hold;
        (ce_in && !(reload && s_q.ldok)) |=> $stable(s_q.presc_act);
    endproperty
    a_divider_hold: assert property (p_divider_hold) else $error("divider changed early");

    property p_flag_set;
        (reload && ce_in) |=> s_q.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("reload flag not set");

    property p_flag_keep;
        (wr_fq && pwdata_in[0] && !s_q.flag_arm && s_q.flag && ce_in) |=> s_q.flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag cleared unarmed");

    property p_irq_withdraw;
        (wr_fq && pwdata_in[`BIT_RELOAD_FLAG] && s_q.flag_arm && !reload && ce_in)
            |=> !gen_b_reload_irq_out;
    endproperty
    a_irq_withdraw: assert property (p_irq_withdraw) else $error("irq outlived flag");

    c_loaded: cover property (reload && s_q.ldok);
    c_flag_cleared: cover property ($fell(s_q.flag));
    c_ldok_set: cover property ($rose(s_q.ldok));
    c_half_reload: cover property (reload && half_pt);

endmodule
`default_nettype wire

// [pwm_switch_driver_model.sv]
// behavioural model of the two power switch drivers on pins two and three
// assumes: pins are registered on core_clk_in; high turns a switch on
`timescale 1ns/1ps
`default_nettype none

module pwm_switch_driver_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // gate drive from the generator
    input wire logic gate_two_in,
    input wire logic gate_three_in,
    // fault observation
    output logic [15:0] overlap_count_out
);
    // both switches of one leg on at once would short the supply
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overlap_count_out <= 16'h0000;
        end else if (gate_two_in && gate_three_in) begin
            overlap_count_out <= overlap_count_out + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the generator B reload control block
// assumes: design files and the switch driver model compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct {
        logic mode;
        logic [6:0] idx;
        logic [31:0] wd;
        logic [31:0] msk;
        logic [31:0] exp;
    } row_type;
    logic clk, rst_n, psel, penable, pwrite, mode, center, pready, pslverr, err;
    logic pin2, pin3, gen_irq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ovr, lvl;
    logic [15:0] overlap;
    int mismatches, checked, hi, p, p0, p1;
    row_type rows [8];

    pwm_gen_b_reload_control u_dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .multi_generator_mode_in(mode),
        .center_aligned_in(center), .output_override_control_in(ovr),
        .override_level_in(lvl), .output_pin_two_out(pin2),
        .output_pin_three_out(pin3), .gen_b_reload_irq_out(gen_irq), .irq_out(irq)
    );

    pwm_switch_driver_model u_drv (
        .core_clk_in(clk), .rst_n_in(rst_n), .gate_two_in(pin2),
        .gate_three_in(pin3), .overlap_count_out(overlap)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t bit %b want %b", $time, got, exp);
        end
    endtask

    // no wait-state count assumed: poll pready under a bound
    task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {3'b000, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic wr_reg(input logic [6:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [31:0] msk,
                          input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd & msk, exp);
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 3000);
        t = int'($time / 40);
        if (n >= 3000) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // cycles between two reloads, seen through the status bit
    task automatic period(output int pr);
        int t1, t2;
        wr_reg(7'h50, 32'h1);
        wait_irq(t1);
        wr_reg(7'h50, 32'h1);
        wait_irq(t2);
        pr = t2 - t1;
    endtask

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, center} = 4'h0;
        mode = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        ovr = 2'b00;
        lvl = 2'b00;
        rows = '{
            '{1'b0, 7'h28, 32'h83, 32'hFF, 32'h0},
            '{1'b1, 7'h2C, 32'h10, 32'h7FFF, 32'h10},
            '{1'b1, 7'h40, 32'h8, 32'hFFFF, 32'h8},
            '{1'b0, 7'h40, 32'h5, 32'hFFFF, 32'h8},
            '{1'b1, 7'h29, 32'hF6, 32'hFE, 32'hF6},
            '{1'b1, 7'h29, 32'h0, 32'hFE, 32'h0},
            '{1'b1, 7'h51, 32'h1, 32'h3, 32'h1},
            '{1'b1, 7'h2A, 32'h55, 32'h7FFF, 32'h0}
        };
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            mode <= rows[i].mode;
            wr_reg(rows[i].idx, rows[i].wd);
            rd_chk(rows[i].idx, rows[i].msk, rows[i].exp);
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(7'h2C, 32'h7FFF, 32'h1);
        rd_chk(7'h40, 32'hFFFF, 32'h0);
        rd_chk(7'h28, 32'hFF, 32'h0);
        chk_bit(irq | gen_irq | pin2 | pin3, 1'b0);
        wr_reg(7'h2C, 32'h10);
        wr_reg(7'h40, 32'h8);
        wr_reg(7'h51, 32'h1);
        // load-okay needs a read of zero first
        wr_reg(7'h28, 32'h0);
        wr_reg(7'h28, 32'h2);
        rd_chk(7'h28, 32'hFF, 32'h0);
        wr_reg(7'h28, 32'h3);
        rd_chk(7'h28, 32'hFF, 32'h3);
        wr_reg(7'h28, 32'h83);
        period(p);
        chk(p, 16);
        rd_chk(7'h28, 32'hFF, 32'h81);
        chk_bit(gen_irq, 1'b1);
        hi = 0;
        repeat (32) begin
            @(negedge clk);
            hi += pin2;
            chk_bit(pin2 ^ pin3, 1'b1);
        end
        chk(hi, 16);
        for (int d = 0; d < 3; d++) begin
            wr_reg(7'h29, {24'h0, 4'hF, 1'b0, d[1:0], 1'b0});
            rd_chk(7'h28, 32'hFF, 32'h81);
            wr_reg(7'h28, 32'h83);
            period(p);
            chk(p, 256 << d);
        end
        rd_chk(7'h29, 32'h1, 32'h1);
        wr_reg(7'h29, 32'hF5);
        rd_chk(7'h29, 32'hFF, 32'hF4);
        chk_bit(gen_irq, 1'b0);
        wr_reg(7'h50, 32'h1);
        wait_irq(p);
        rd_chk(7'h29, 32'hFF, 32'hF5);
        // a reload between read and write voids the clear
        wr_reg(7'h50, 32'h1);
        wait_irq(p);
        wr_reg(7'h29, 32'hF5);
        rd_chk(7'h29, 32'hFF, 32'hF5);
        wr_reg(7'h51, 32'h0);
        @(negedge clk);
        chk_bit(irq, 1'b0);
        wr_reg(7'h51, 32'h1);
        @(negedge clk);
        chk_bit(irq, 1'b1);
        wr_reg(7'h50, 32'h1);
        @(negedge clk);
        chk_bit(irq, 1'b0);
        wr_reg(7'h28, 32'h80);
        @(negedge clk);
        chk_bit(gen_irq, 1'b0);
        wr_reg(7'h28, 32'h81);
        @(negedge clk);
        chk_bit(gen_irq, 1'b1);
        @(posedge clk);
        mode <= 1'b0;
        @(negedge clk);
        chk_bit(gen_irq, 1'b0);
        @(posedge clk);
        mode <= 1'b1;
        center <= 1'b1;
        wr_reg(7'h29, 32'h04);
        period(p0);
        period(p0);
        wr_reg(7'h29, 32'h0C);
        period(p1);
        period(p1);
        chk(p0, 2 * p1);
        chk(p1, 64);
        wr_reg(7'h28, 32'h0);
        ovr <= 2'b11;
        lvl <= 2'b01;
        repeat (3) @(posedge clk);
        chk_bit(pin2 & ~pin3, 1'b1);
        ovr <= 2'b00;
        repeat (3) @(posedge clk);
        chk_bit(pin2 | pin3, 1'b0);
        apb(1'b0, 7'h7F, 32'h0);
        chk(rd, 32'h0);
        chk_bit(err, 1'b1);
        chk(overlap, 32'h0);
        wrap_up();
    end
endmodule

`default_nettype wire
